/* rtl/slip_status_pkg.sv */
// Purpose: shared constants and types for the slip buffer event status block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one clock clk_sys
// Notes:   four address units per 32-bit word, register data in the low byte except the fill word

package slip_status_pkg;

    // ========================================================================
    // register map (byte addresses)
    localparam logic [15:0] STATUS_OFFSET = 16'h0B08;
    localparam logic [15:0] ENABLE_OFFSET = 16'h0B0C;
    localparam logic [15:0] CLEAR_OFFSET  = 16'h0B10;
    localparam logic [15:0] FILL_OFFSET   = 16'h0B14;

    // ========================================================================
    // status byte and fill word layout
    localparam int TX_OVF_BIT  = 7;
    localparam int TX_UNF_BIT  = 6;
    localparam int TX_SLIP_BIT = 5;
    localparam int LOOP_SYNC_BIT = 4;
    localparam int MF_LOCK_BIT = 3;
    localparam int RX_OVF_BIT  = 2;
    localparam int RX_UNF_BIT  = 1;
    localparam int RX_SLIP_BIT = 0;
    localparam int FILL_RX_LSB = 0;
    localparam int FILL_TX_LSB = 8;

    localparam logic [7:0] EVENT_MASK   = 8'hE7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // ========================================================================
    // elastic store geometry: two frames of slots
    localparam int          PTR_W             = 6;
    localparam int          FILL_W            = 7;
    localparam logic [5:0]  FRAME_SLOTS       = 6'h20;
    localparam logic [6:0]  BUF_SLOTS         = 7'h40;
    localparam logic [6:0]  FILL_AFTER_DROP   = 7'h21;
    localparam logic [6:0]  FILL_AFTER_REPLAY = 7'h1F;

    // ========================================================================
    // bus answer phase
    typedef enum logic [0:0] {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_phase_e;

endpackage

/* rtl/slip_if.sv */
// Purpose: carries one elastic store's requests and slip results
// Assumes: all signals on clk_sys
// Notes:   ctrl side owns pointers and event pulses

`timescale 1ns/1ps

interface slip_if;
    import slip_status_pkg::*;

    logic              wr_req;
    logic              rd_req;
    logic              wr_en;
    logic [PTR_W-1:0]  wr_addr;
    logic              rd_en;
    logic [PTR_W-1:0]  rd_addr;
    logic              overflow;
    logic              underflow;
    logic [FILL_W-1:0] fill;

    modport ctrl (
        input  wr_req,
        input  rd_req,
        output wr_en,
        output wr_addr,
        output rd_en,
        output rd_addr,
        output overflow,
        output underflow,
        output fill
    );

    modport user (
        output wr_req,
        output rd_req,
        input  wr_en,
        input  wr_addr,
        input  rd_en,
        input  rd_addr,
        input  overflow,
        input  underflow,
        input  fill
    );
endinterface

/* rtl/slip_ctrl.sv */
// Purpose: pointer and slip control of one two-frame elastic store
// Assumes: one slot written per wr_req, one slot read per rd_req
// Notes:   addresses and strobes are registered, storage lags one cycle

`timescale 1ns/1ps

module slip_ctrl
    import slip_status_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic srst,
    slip_if.ctrl      sb
);

    typedef struct packed {
        logic [PTR_W-1:0]  wr_ptr;
        logic [PTR_W-1:0]  rd_ptr;
        logic [FILL_W-1:0] fill;
        logic              wr_en;
        logic [PTR_W-1:0]  wr_addr;
        logic              rd_en;
        logic [PTR_W-1:0]  rd_addr;
        logic              overflow;
        logic              underflow;
    } slip_state_s;

    slip_state_s st_reg;
    slip_state_s st_next;
    logic        ovf;
    logic        unf;

    // a read in the same cycle frees a slot, so that write is no overflow
    assign ovf = sb.wr_req && !sb.rd_req && (st_reg.fill == BUF_SLOTS);
    assign unf = sb.rd_req && (st_reg.fill == 7'h00);

    // ========================================================================
    // next state
    always_comb begin
        st_next           = st_reg;
        st_next.wr_en     = 1'b0;
        st_next.rd_en     = 1'b0;
        st_next.overflow  = 1'b0;
        st_next.underflow = 1'b0;
        if (sb.rd_req) begin
            st_next.rd_en = 1'b1;
            if (unf) begin
                // step back a whole frame and read it out again
                st_next.rd_addr   = st_reg.rd_ptr - FRAME_SLOTS;
                st_next.fill      = FILL_AFTER_REPLAY;
                st_next.underflow = 1'b1;
            end else begin
                st_next.rd_addr = st_reg.rd_ptr;
                st_next.fill    = st_reg.fill - 7'h01;
            end
            st_next.rd_ptr = st_next.rd_addr + 6'h01;
        end
        if (sb.wr_req) begin
            st_next.wr_en   = 1'b1;
            st_next.wr_addr = st_reg.wr_ptr;
            st_next.wr_ptr  = st_reg.wr_ptr + 6'h01;
            if (ovf) begin
                // the oldest whole frame is dropped, never a lone slot
                st_next.rd_ptr   = st_reg.rd_ptr + FRAME_SLOTS;
                st_next.fill     = FILL_AFTER_DROP;
                st_next.overflow = 1'b1;
            end else begin
                st_next.fill = st_next.fill + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sb.wr_en     = st_reg.wr_en;
    assign sb.wr_addr   = st_reg.wr_addr;
    assign sb.rd_en     = st_reg.rd_en;
    assign sb.rd_addr   = st_reg.rd_addr;
    assign sb.overflow  = st_reg.overflow;
    assign sb.underflow = st_reg.underflow;
    assign sb.fill      = st_reg.fill;

    // ========================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    chk_fill_in_range: assert property (st_reg.fill <= BUF_SLOTS)
        else $error("fill level above buffer size");

    chk_drop_whole_frame: assert property (ovf |=> (st_reg.overflow && st_reg.fill == FILL_AFTER_DROP
        && st_reg.rd_ptr == $past(st_reg.rd_ptr) + FRAME_SLOTS))
        else $error("overflow did not drop exactly one frame");

    chk_replay_whole_frame: assert property ((unf && !sb.wr_req) |=> (st_reg.underflow && st_reg.rd_en
        && st_reg.fill == FILL_AFTER_REPLAY && st_reg.rd_addr == $past(st_reg.rd_ptr) - FRAME_SLOTS))
        else $error("underflow did not replay one frame");

endmodule

/* rtl/slip_event_status.sv */
// Purpose: slip event status, enable and clear registers for tx and rx elastic stores
// Assumes: Avalon-MM slave with waitrequest; framer lock inputs come from logic on clk_sys
// Notes:   each access is answered with waitrequest low in the cycle after it is taken
//
// How it works
// - a write with no read in the same cycle into the full transmit store drops one whole frame and sets bit 7.
// - a read from the empty transmit store replays one whole frame and sets bit 6.
// - bit 5 is set on every transmit drop or replay.
// - an underflow replays a whole previously held frame, keeping read alignment.
// - an overflow drops a whole frame of data, keeping write alignment.
// - event flags stay set until the status register is read or a clear write hits them, and reset to 0.
// - bit 4 shows 1 while frame sync is held in loop-carrier superframe mode.
// - bit 3 follows the receive multiframe lock, low on loss and high on lock.
// - a write with no read in the same cycle into the full receive store drops one whole frame and sets bit 2.
// - a read from the empty receive store replays one whole frame and sets bit 1.
// - bit 0 is set on every receive drop or replay.

`timescale 1ns/1ps

module slip_event_status
    import slip_status_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        tx_wr_req,
    input  wire logic        tx_rd_req,
    input  wire logic        rx_wr_req,
    input  wire logic        rx_rd_req,
    input  wire logic        loop_carrier_sync_in,
    input  wire logic        multiframe_lock_in,
    output logic             tx_wr_en,
    output logic      [5:0]  tx_wr_addr,
    output logic             tx_rd_en,
    output logic      [5:0]  tx_rd_addr,
    output logic             rx_wr_en,
    output logic      [5:0]  rx_wr_addr,
    output logic             rx_rd_en,
    output logic      [5:0]  rx_rd_addr,
    output logic             irq
);

    // ========================================================================
    // elastic store controllers
    slip_if tx_sb ();
    slip_if rx_sb ();

    assign tx_sb.wr_req = tx_wr_req;
    assign tx_sb.rd_req = tx_rd_req;
    assign rx_sb.wr_req = rx_wr_req;
    assign rx_sb.rd_req = rx_rd_req;

    slip_ctrl u_tx_ctrl (
        .clk_sys (clk_sys),
        .srst    (srst),
        .sb      (tx_sb.ctrl)
    );

    slip_ctrl u_rx_ctrl (
        .clk_sys (clk_sys),
        .srst    (srst),
        .sb      (rx_sb.ctrl)
    );

    assign tx_wr_en   = tx_sb.wr_en;
    assign tx_wr_addr = tx_sb.wr_addr;
    assign tx_rd_en   = tx_sb.rd_en;
    assign tx_rd_addr = tx_sb.rd_addr;
    assign rx_wr_en   = rx_sb.wr_en;
    assign rx_wr_addr = rx_sb.wr_addr;
    assign rx_rd_en   = rx_sb.rd_en;
    assign rx_rd_addr = rx_sb.rd_addr;

    // ========================================================================
    // slip events as a status-shaped vector
    logic [7:0] slip_events;

    assign slip_events[TX_OVF_BIT]    = tx_sb.overflow;
    assign slip_events[TX_UNF_BIT]    = tx_sb.underflow;
    assign slip_events[TX_SLIP_BIT]   = tx_sb.overflow || tx_sb.underflow;
    assign slip_events[LOOP_SYNC_BIT] = 1'b0;
    assign slip_events[MF_LOCK_BIT]   = 1'b0;
    assign slip_events[RX_OVF_BIT]    = rx_sb.overflow;
    assign slip_events[RX_UNF_BIT]    = rx_sb.underflow;
    assign slip_events[RX_SLIP_BIT]   = rx_sb.overflow || rx_sb.underflow;

    // ========================================================================
    // register state
    typedef struct packed {
        bus_phase_e  phase;
        logic        waitrequest;
        logic [31:0] readdata;
        logic [7:0]  status;
        logic [7:0]  enable;
        logic        irq;
    } reg_state_s;

    reg_state_s st_reg;
    reg_state_s st_next;
    logic       take;
    logic       status_read;

    // a request is taken only while waitrequest is high, so a held request is never taken twice
    assign take        = (avs_read || avs_write) && st_reg.waitrequest;
    assign status_read = take && avs_read && (avs_address == STATUS_OFFSET);

    // ========================================================================
    // next state
    always_comb begin
        logic [7:0] clear_bits;
        clear_bits          = 8'h00;
        st_next             = st_reg;
        st_next.waitrequest = 1'b1;

        case (st_reg.phase)
            BUS_IDLE: begin
                if (take) begin
                    st_next.phase       = BUS_ANSWER;
                    st_next.waitrequest = 1'b0;
                end
            end
            BUS_ANSWER: begin
                st_next.phase = BUS_IDLE;
            end
            default: begin
                st_next.phase = BUS_IDLE;
            end
        endcase

        if (take && avs_read) begin
            case (avs_address)
                STATUS_OFFSET: begin
                    st_next.readdata = {24'h000000, st_reg.status};
                    clear_bits       = EVENT_MASK;
                end
                ENABLE_OFFSET: begin
                    st_next.readdata = {24'h000000, st_reg.enable};
                end
                FILL_OFFSET: begin
                    st_next.readdata = {17'h0, tx_sb.fill, 1'b0, rx_sb.fill};
                end
                default: begin
                    // clear register is write-only; unmapped words read zero
                    st_next.readdata = 32'h00000000;
                end
            endcase
        end

        if (take && avs_write && avs_byteenable[0]) begin
            case (avs_address)
                ENABLE_OFFSET: begin
                    st_next.enable = avs_writedata[7:0] & EVENT_MASK;
                end
                CLEAR_OFFSET: begin
                    clear_bits = avs_writedata[7:0] & EVENT_MASK;
                end
                default: begin
                    st_next.enable = st_reg.enable;
                end
            endcase
        end

        // set beats clear, so an event in the read cycle survives the read
        st_next.status = ((st_reg.status & ~clear_bits) | slip_events) & EVENT_MASK;
        st_next.status[LOOP_SYNC_BIT] = loop_carrier_sync_in;
        st_next.status[MF_LOCK_BIT]   = multiframe_lock_in;

        st_next.irq = |(st_next.status & st_next.enable & EVENT_MASK);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg.phase       <= BUS_IDLE;
            st_reg.waitrequest <= 1'b1;
            st_reg.readdata    <= 32'h00000000;
            st_reg.status      <= STATUS_RESET;
            st_reg.enable      <= ENABLE_RESET;
            st_reg.irq         <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata    = st_reg.readdata;
    assign avs_waitrequest = st_reg.waitrequest;
    assign irq             = st_reg.irq;

    // ========================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_one_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    sequence s_status_taken;
        s_taken and (avs_read && avs_address == STATUS_OFFSET);
    endsequence

    property p_answered_once;
        s_taken |=> s_one_answer;
    endproperty

    chk_bus_answer_once: assert property (p_answered_once)
        else $error("bus request not answered by a single waitrequest low cycle");

    chk_tx_full_flag: assert property (tx_sb.overflow |=> st_reg.status[TX_OVF_BIT])
        else $error("tx overflow did not set its flag");

    chk_tx_empty_flag: assert property (tx_sb.underflow |=> st_reg.status[TX_UNF_BIT])
        else $error("tx underflow did not set its flag");

    chk_tx_slip_flag: assert property ((tx_sb.overflow || tx_sb.underflow) |=> st_reg.status[TX_SLIP_BIT])
        else $error("tx slip did not set its flag");

    chk_rx_full_flag: assert property (rx_sb.overflow |=> st_reg.status[RX_OVF_BIT])
        else $error("rx overflow did not set its flag");

    chk_rx_empty_flag: assert property (rx_sb.underflow |=> st_reg.status[RX_UNF_BIT])
        else $error("rx underflow did not set its flag");

    chk_rx_slip_flag: assert property ((rx_sb.overflow || rx_sb.underflow) |=> st_reg.status[RX_SLIP_BIT])
        else $error("rx slip did not set its flag");

    chk_read_clears_flags: assert property ((s_status_taken and (slip_events == 8'h00))
        |=> ((st_reg.status & EVENT_MASK) == 8'h00) && (avs_readdata[7:0] == $past(st_reg.status)))
        else $error("status read did not return and clear the event flags");

    chk_read_keeps_event: assert property ((s_status_taken and (slip_events != 8'h00))
        |=> ((st_reg.status & $past(slip_events)) == $past(slip_events)))
        else $error("event in the read cycle was lost");

    chk_flags_sticky: assert property ((!take && st_reg.status[TX_OVF_BIT]) |=> st_reg.status[TX_OVF_BIT])
        else $error("tx overflow flag dropped without a read or clear");

    chk_loop_sync_read: assert property (s_status_taken
        |=> avs_readdata[LOOP_SYNC_BIT] == $past(loop_carrier_sync_in, 2))
        else $error("loop-carrier sync bit does not follow its input");

    chk_mf_lock_read: assert property (s_status_taken
        |=> avs_readdata[MF_LOCK_BIT] == $past(multiframe_lock_in, 2))
        else $error("multiframe lock bit does not follow its input");

    chk_irq_follows: assert property (irq == |(st_reg.status & st_reg.enable & EVENT_MASK))
        else $error("interrupt does not match enabled status");

    // ========================================================================
    // register side details and flag causes
    chk_read_returns_status: assert property (status_read
        |=> avs_readdata == {24'h000000, $past(st_reg.status)})
        else $error("status read returned a stale value");

    chk_clear_write_bits: assert property ((take && avs_write && avs_address == CLEAR_OFFSET
        && avs_byteenable[0] && slip_events == 8'h00)
        |=> ((st_reg.status & EVENT_MASK) == ($past(st_reg.status) & ~$past(avs_writedata[7:0]) & EVENT_MASK)))
        else $error("clear write did not clear exactly the written bits");

    chk_status_not_writable: assert property ((take && avs_write && avs_address == STATUS_OFFSET
        && slip_events == 8'h00) |=> ((st_reg.status & EVENT_MASK) == ($past(st_reg.status) & EVENT_MASK)))
        else $error("write to the status register changed an event flag");

    chk_enable_masked: assert property ((st_reg.enable & ~EVENT_MASK) == 8'h00)
        else $error("enable holds a bit outside the event flags");

    chk_readdata_upper: assert property (avs_readdata[31:15] == 17'h0)
        else $error("read data has bits set above the fill fields");

    chk_answer_ends: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest stayed low for more than one cycle");

    chk_tx_slip_cause: assert property ($rose(st_reg.status[TX_SLIP_BIT])
        |-> (st_reg.status[TX_OVF_BIT] || st_reg.status[TX_UNF_BIT]))
        else $error("tx slip flag rose without an overflow or underflow flag");

    chk_rx_slip_cause: assert property ($rose(st_reg.status[RX_SLIP_BIT])
        |-> (st_reg.status[RX_OVF_BIT] || st_reg.status[RX_UNF_BIT]))
        else $error("rx slip flag rose without an overflow or underflow flag");

    chk_slip_events_apart: assert property (!(tx_sb.overflow && tx_sb.underflow)
        && !(rx_sb.overflow && rx_sb.underflow))
        else $error("overflow and underflow pulsed together on one store");

    chk_loop_sync_live: assert property (!$past(srst)
        |-> st_reg.status[LOOP_SYNC_BIT] == $past(loop_carrier_sync_in))
        else $error("loop-carrier sync bit lags its input by more than a cycle");

    chk_mf_lock_live: assert property (!$past(srst)
        |-> st_reg.status[MF_LOCK_BIT] == $past(multiframe_lock_in))
        else $error("multiframe lock bit lags its input by more than a cycle");

endmodule

/* test/framer_side_model.sv */
// Purpose: framer side of both elastic stores, slot requests and lock levels
// Assumes: one slot per high cycle of a request, all on clk_sys
// Notes:   requests move only just after a rising edge
`timescale 1ns/1ps

module framer_side_model (
    input  wire logic clk_sys,
    output logic      tx_wr_req,
    output logic      tx_rd_req,
    output logic      rx_wr_req,
    output logic      rx_rd_req,
    output logic      loop_carrier_sync_in,
    output logic      multiframe_lock_in
);
    initial begin
        tx_wr_req = 1'b0;
        tx_rd_req = 1'b0;
        rx_wr_req = 1'b0;
        rx_rd_req = 1'b0;
        loop_carrier_sync_in = 1'b0;
        multiframe_lock_in = 1'b0;
    end

    // ========================================
    // burst of n back-to-back slots on one store
    task automatic burst(input bit rx, input bit rd, input int n);
        @(posedge clk_sys);
        {rx_rd_req, rx_wr_req, tx_rd_req, tx_wr_req} <= 4'h1 << {rx, rd};
        repeat (n) @(posedge clk_sys);
        {rx_rd_req, rx_wr_req, tx_rd_req, tx_wr_req} <= 4'h0;
    endtask
endmodule

/* test/slip_buffer_event_status_tb.sv */
// Purpose: self-checking bench for the slip event status block
// Assumes: one access answered per two cycles, status bits set two edges after a slot request
// Notes:   one scenario per task, each judged before it returns
`timescale 1ns/1ps

module slip_buffer_event_status_tb
    import slip_status_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] avs_address = 16'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        tx_wr_req, tx_rd_req, rx_wr_req, rx_rd_req, loop_carrier_sync_in, multiframe_lock_in;
    logic        tx_wr_en, tx_rd_en, rx_wr_en, rx_rd_en, irq;
    logic [5:0]  tx_wr_addr, tx_rd_addr, rx_wr_addr, rx_rd_addr;
    logic [5:0]  last_rd [2];
    logic [5:0]  last_wr [2];
    int          mismatches = 0;
    int          total_checks = 0;

    always #2.5 clk_sys = ~clk_sys;

    slip_event_status i_slip_event_status (
        .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_wr_req(tx_wr_req), .tx_rd_req(tx_rd_req), .rx_wr_req(rx_wr_req), .rx_rd_req(rx_rd_req),
        .loop_carrier_sync_in(loop_carrier_sync_in), .multiframe_lock_in(multiframe_lock_in),
        .tx_wr_en(tx_wr_en), .tx_wr_addr(tx_wr_addr), .tx_rd_en(tx_rd_en), .tx_rd_addr(tx_rd_addr),
        .rx_wr_en(rx_wr_en), .rx_wr_addr(rx_wr_addr), .rx_rd_en(rx_rd_en), .rx_rd_addr(rx_rd_addr),
        .irq(irq)
    );

    framer_side_model i_framer_side_model (
        .clk_sys(clk_sys), .tx_wr_req(tx_wr_req), .tx_rd_req(tx_rd_req), .rx_wr_req(rx_wr_req),
        .rx_rd_req(rx_rd_req), .loop_carrier_sync_in(loop_carrier_sync_in),
        .multiframe_lock_in(multiframe_lock_in)
    );

    // ========================================
    // monitors and shared tasks
    always @(posedge clk_sys) begin
        if (tx_rd_en === 1'b1) last_rd[0] <= tx_rd_addr;
        if (rx_rd_en === 1'b1) last_rd[1] <= rx_rd_addr;
        if (tx_wr_en === 1'b1) last_wr[0] <= tx_wr_addr;
        if (rx_wr_en === 1'b1) last_wr[1] <= rx_wr_addr;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [15:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        forever begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(0, a, 8'h0, q);
        chk(q, exp);
    endtask

    task automatic slots(input bit rx, input bit rd, input int n);
        i_framer_side_model.burst(rx, rd, n);
        repeat (3) @(posedge clk_sys);
    endtask

    // ========================================
    // scenarios
    task automatic reset_values();
        logic [31:0] q;
        rd_chk(STATUS_OFFSET, 32'h0);
        rd_chk(ENABLE_OFFSET, 32'h0);
        rd_chk(FILL_OFFSET, 32'h0);
        rd_chk(16'h0B20, 32'h0);
        chk(irq, 1'b0);
        bus(1, ENABLE_OFFSET, 8'hFF, q);
        rd_chk(ENABLE_OFFSET, 32'hE7);
        $display("test reset_values done");
    endtask

    // full drop then replay on one store; rx runs with its interrupt masked
    task automatic slip_cycle(input bit rx);
        logic [31:0] q;
        bus(1, ENABLE_OFFSET, rx ? 8'h00 : 8'hFF, q);
        slots(rx, 0, 64);
        chk(last_wr[rx], 6'h3F);
        rd_chk(STATUS_OFFSET, 32'h0);
        slots(rx, 0, 1);
        chk(last_wr[rx], 6'h00);
        chk(irq, !rx);
        rd_chk(STATUS_OFFSET, rx ? 32'h05 : 32'hA0);
        chk(irq, 1'b0);
        rd_chk(STATUS_OFFSET, 32'h0);
        rd_chk(FILL_OFFSET, rx ? 32'h1F21 : 32'h2100);
        slots(rx, 1, 1);
        chk(last_rd[rx], 6'h20);
        slots(rx, 1, 32);
        slots(rx, 1, 1);
        chk(last_rd[rx], 6'h21);
        rd_chk(STATUS_OFFSET, rx ? 32'h03 : 32'h62 & 32'h60);
        $display("test slip_cycle done");
    endtask

    // underflow lands around the take edge of a status read
    task automatic read_race();
        logic [31:0] q1, q2;
        for (int k = 0; k < 4; k++) begin
            slots(0, 1, 31);
            fork
                i_framer_side_model.burst(0, 1, 1);
                begin
                    repeat (k) @(posedge clk_sys);
                    bus(0, STATUS_OFFSET, 8'h0, q1);
                end
            join
            repeat (3) @(posedge clk_sys);
            bus(0, STATUS_OFFSET, 8'h0, q2);
            chk((q1 | q2) & 32'h60, 32'h60);
        end
        bus(1, ENABLE_OFFSET, 8'hFF, q1);
        slots(0, 1, 32);
        chk(irq, 1'b1);
        bus(1, CLEAR_OFFSET, 8'hFF, q1);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        rd_chk(STATUS_OFFSET, 32'h0);
        $display("test read_race done");
    endtask

    task automatic lock_flags();
        logic [31:0] q;
        for (int s = 0; s < 4; s++) begin
            i_framer_side_model.loop_carrier_sync_in <= s[1];
            i_framer_side_model.multiframe_lock_in <= s[0];
            bus(1, STATUS_OFFSET, 8'hFF, q);
            repeat (2) @(posedge clk_sys);
            rd_chk(STATUS_OFFSET, {27'h0, s[1:0], 3'h0});
        end
        $display("test lock_flags done");
    endtask

    // ========================================
    // sequence, verdict and watchdog
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        reset_values();
        slip_cycle(0);
        slip_cycle(1);
        read_race();
        lock_flags();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        give_verdict();
    end
endmodule
